// ---- common/adc_ctrl_pkg.sv ----
// Register map, field layout, reset values and state types for the
// converter control block.
// Assumes a 32-bit AHB-Lite slave, one aligned word per 8-bit register.
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CLOCK_GATE = 8'h00;
  localparam logic [7:0] OFS_MODE0 = 8'h04;
  localparam logic [7:0] OFS_MASK1H = 8'h08;
  localparam logic [7:0] OFS_FLAG1H = 8'h0C;
  localparam logic [7:0] OFS_PRIO_HI = 8'h10;
  localparam logic [7:0] OFS_PRIO_LO = 8'h14;
  localparam logic [7:0] OFS_PORT2_DIR = 8'h18;
  localparam logic [7:0] OFS_TRIG_CFG = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_CLOCK_GATE = 5;
  localparam int unsigned BIT_RUN = 7;
  localparam int unsigned BIT_CHSEL = 6;
  localparam int unsigned BIT_FR_LSB = 3;
  localparam int unsigned BIT_LV_LSB = 1;
  localparam int unsigned BIT_CMP_EN = 0;
  localparam int unsigned BIT_CONV_END = 0;
  localparam int unsigned BIT_WAIT_MODE = 0;
  localparam int unsigned IRQ_CONV_END = 0;
  localparam int unsigned IRQ_SCAN_DONE = 1;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CLOCK_GATE = 8'h00;
  localparam logic [7:0] RST_MODE0 = 8'h00;
  localparam logic [7:0] RST_MASK1H = 8'hFF;
  localparam logic [7:0] RST_FLAG1H = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'hFF;
  localparam logic [7:0] RST_PORT2_DIR = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [11:0] FAD_CLOCKS_NORMAL1 = 12'h013;
  localparam logic [11:0] FAD_CLOCKS_NORMAL2 = 12'h011;
  localparam logic [1:0] LAST_SCAN_CHANNEL = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_STAB, SEQ_CONV} seq_t;

  typedef struct packed {
    logic clk_en;
    logic comparator_on;
    logic busy;
    logic [1:0] channel;
  } conv_pins_t;

  typedef struct packed {
    logic [7:0] gate;
    logic [7:0] mode0;
    logic [7:0] mask1h;
    logic [7:0] flag1h;
    logic [7:0] prio_hi;
    logic [7:0] prio_lo;
    logic [7:0] port2_dir;
    logic [7:0] trig_cfg;
    logic [7:0] irq_status;
    logic [7:0] irq_enable;
    seq_t seq;
    logic [11:0] cnt;
    logic [1:0] chan;
    logic [2:0] trg_ff;
    logic trg_stable;
    logic ap_valid;
    logic ap_write;
    logic ap_hit;
    logic [7:0] ap_addr;
    logic rd_wait;
    logic ready;
    logic [31:0] rdata;
  } st_t;

endpackage

// ---- hw/adc_control_and_end_interrupt.sv ----
// Converter control registers, conversion sequencer and end interrupt.
// Assumes one AHB-Lite master and a hardware trigger pin from outside.
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RQ1] Gate bit low: clock stopped, mode and trigger config writes ignored
// [RQ2] Gate bit high: clock on, registers accessible
// [RQ3] Run bit zero stops conversion, reads idle
// [RQ4] Run bit one converts; reads busy
// [RQ5] Wait mode busy covers stabilisation and conversion
// [RQ6] Comparator enable bit stops or runs comparator
// [RQ7] Mode register holds run, mode, clock, timing
// [RQ8] Mode bit zero selects single channel
// [RQ9] Mode bit one scans four channels
// [RQ10] Mask bit zero enables end interrupt
// [RQ11] Request flag pending; software clears writing zero
// [RQ12] Two priority bits, zero highest, three lowest
// [RQ13] Port direction zero drives, one inputs
// [RQ14] Software halts converter before configuring it
// [RQ15] Request forwarded when flagged and unmasked
module adc_control_and_end_interrupt #(
  parameter int unsigned STAB_CYCLES = 16,
  parameter int unsigned PORT_PINS = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic hw_trigger,
  output adc_ctrl_pkg::conv_pins_t conv_pins,
  output logic [PORT_PINS-1:0] port2_out_en,
  output logic conv_end_request,
  output logic [1:0] conv_end_priority,
  output logic irq
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Conversion clock divider of the clock-select field
  function automatic logic [11:0] conv_div(input logic [2:0] fr);
    case (fr)
      3'h0: conv_div = 12'h040;
      3'h1: conv_div = 12'h020;
      3'h2: conv_div = 12'h010;
      3'h3: conv_div = 12'h008;
      3'h4: conv_div = 12'h006;
      3'h5: conv_div = 12'h005;
      3'h6: conv_div = 12'h004;
      default: conv_div = 12'h002;
    endcase
  endfunction

  // Core clocks per conversion, minus one for the down counter
  function automatic logic [11:0] conv_load(input logic [7:0] m);
    logic [11:0] n;
    n = m[BIT_LV_LSB] ? FAD_CLOCKS_NORMAL2 : FAD_CLOCKS_NORMAL1;
    conv_load = 12'(conv_div(m[BIT_FR_LSB+:3]) * n - 12'h001);
  endfunction

  // Read view of a register; unmapped words read as zero
  function automatic logic [31:0] rd_word(input st_t s, input logic [7:0] a);
    logic [7:0] m;
    m = s.mode0;
    if (s.trig_cfg[BIT_WAIT_MODE]) begin
      m[BIT_RUN] = (s.seq != SEQ_IDLE);
    end
    case (a)
      OFS_CLOCK_GATE: rd_word = {24'h000000, s.gate};
      OFS_MODE0: rd_word = {24'h000000, m};
      OFS_MASK1H: rd_word = {24'h000000, s.mask1h};
      OFS_FLAG1H: rd_word = {24'h000000, s.flag1h};
      OFS_PRIO_HI: rd_word = {24'h000000, s.prio_hi};
      OFS_PRIO_LO: rd_word = {24'h000000, s.prio_lo};
      OFS_PORT2_DIR: rd_word = {24'h000000, s.port2_dir};
      OFS_TRIG_CFG: rd_word = {24'h000000, s.trig_cfg};
      OFS_IRQ_STATUS: rd_word = {24'h000000, s.irq_status};
      OFS_IRQ_ENABLE: rd_word = {24'h000000, s.irq_enable};
      default: rd_word = 32'h00000000;
    endcase
  endfunction

  localparam logic [11:0] STAB_LOAD = 12'(STAB_CYCLES - 1);

  st_t s;
  st_t next_s;
  logic gate_on;
  logic run;
  logic scan;
  logic wait_mode;
  logic trg_rise;
  logic conv_end;
  logic scan_done;
  logic accept;
  logic wr;
  logic [7:0] wd;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  // Rising pin change counts once stages two and three agree
  assign trg_rise = (s.trg_ff[1] == s.trg_ff[2]) && s.trg_ff[1] && !s.trg_stable;
  assign gate_on = s.gate[BIT_CLOCK_GATE];
  assign run = s.mode0[BIT_RUN] && s.mode0[BIT_CMP_EN];
  assign scan = s.mode0[BIT_CHSEL];
  assign wait_mode = s.trig_cfg[BIT_WAIT_MODE];
  assign conv_end = gate_on && run && (s.seq == SEQ_CONV) && (s.cnt == 12'h000);
  assign scan_done = conv_end && scan && (s.chan == LAST_SCAN_CHANNEL);
  assign accept = hsel && hready && htrans[1];
  assign wr = s.ap_valid && s.ap_write && s.ap_hit;
  assign wd = hwdata[7:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Sequencer first, bus writes after, so a write wins on the same edge
  always_comb begin
    next_s = s;
    next_s.trg_ff = {s.trg_ff[1:0], hw_trigger};
    if (s.trg_ff[1] == s.trg_ff[2]) begin
      next_s.trg_stable = s.trg_ff[1];
    end

    // Stopped clock freezes the sequencer where it stands
    if (gate_on) begin // RQ1 RQ2
      if (!run) begin
        next_s.seq = SEQ_IDLE; // RQ3 RQ6
        next_s.chan = 2'h0;
      end else begin
        case (s.seq)
          SEQ_IDLE: begin
            if (!wait_mode) begin
              next_s.seq = SEQ_CONV; // RQ4
              next_s.cnt = conv_load(s.mode0);
              next_s.chan = 2'h0;
            end else if (trg_rise) begin
              next_s.seq = SEQ_STAB; // RQ5
              next_s.cnt = STAB_LOAD;
              next_s.chan = 2'h0;
            end
          end
          SEQ_STAB: begin
            if (s.cnt == 12'h000) begin
              next_s.seq = SEQ_CONV; // RQ5
              next_s.cnt = conv_load(s.mode0);
            end else begin
              next_s.cnt = s.cnt - 12'h001;
            end
          end
          SEQ_CONV: begin
            if (s.cnt != 12'h000) begin
              next_s.cnt = s.cnt - 12'h001;
            end else if (scan && s.chan != LAST_SCAN_CHANNEL) begin
              next_s.chan = s.chan + 2'h1; // RQ9
              next_s.cnt = conv_load(s.mode0);
            end else begin
              // One-shot: software mode drops run, wait mode re-arms
              next_s.seq = SEQ_IDLE; // RQ8
              next_s.chan = 2'h0;
              if (!wait_mode) begin
                next_s.mode0[BIT_RUN] = 1'b0; // RQ4
              end
            end
          end
          default: begin
            next_s.seq = SEQ_IDLE;
          end
        endcase
      end
    end

    // Register writes in the data phase
    if (wr) begin
      case (s.ap_addr)
        OFS_CLOCK_GATE: next_s.gate = wd;
        OFS_MODE0: begin
          if (gate_on) begin
            next_s.mode0 = wd; // RQ1 RQ7
          end
        end
        OFS_TRIG_CFG: begin
          if (gate_on) begin
            next_s.trig_cfg = wd; // RQ1
          end
        end
        OFS_MASK1H: next_s.mask1h = wd; // RQ10
        OFS_FLAG1H: next_s.flag1h = wd; // RQ11
        OFS_PRIO_HI: next_s.prio_hi = wd; // RQ12
        OFS_PRIO_LO: next_s.prio_lo = wd; // RQ12
        OFS_PORT2_DIR: next_s.port2_dir = wd; // RQ13
        OFS_IRQ_ENABLE: next_s.irq_enable = wd;
        default: begin
        end
      endcase
    end

    // Read data captured one cycle late so prior writes are seen
    if (s.rd_wait) begin
      next_s.rdata = rd_word(s, s.ap_addr);
      next_s.ready = 1'b1;
      next_s.rd_wait = 1'b0;
      if (s.ap_hit && s.ap_addr == OFS_IRQ_STATUS) begin
        next_s.irq_status = 8'h00;
      end
    end

    // Hardware set wins over a software clear in the same cycle
    if (conv_end) begin
      next_s.flag1h[BIT_CONV_END] = 1'b1; // RQ11
      next_s.irq_status[IRQ_CONV_END] = 1'b1;
    end
    if (scan_done) begin
      next_s.irq_status[IRQ_SCAN_DONE] = 1'b1;
    end

    // Address phase capture
    next_s.ap_valid = 1'b0;
    if (accept) begin
      next_s.ap_valid = 1'b1;
      next_s.ap_write = hwrite;
      next_s.ap_addr = haddr[7:0];
      next_s.ap_hit = (haddr[31:8] == 24'h000000) && (hsize == 3'h2);
      if (!hwrite) begin
        next_s.rd_wait = 1'b1;
        next_s.ready = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s.gate <= RST_CLOCK_GATE;
      s.mode0 <= RST_MODE0;
      s.mask1h <= RST_MASK1H;
      s.flag1h <= RST_FLAG1H;
      s.prio_hi <= RST_PRIO;
      s.prio_lo <= RST_PRIO;
      s.port2_dir <= RST_PORT2_DIR;
      s.trig_cfg <= RST_ZERO;
      s.irq_status <= RST_ZERO;
      s.irq_enable <= RST_ZERO;
      s.seq <= SEQ_IDLE;
      s.cnt <= 12'h000;
      s.chan <= 2'h0;
      s.trg_ff <= 3'h0;
      s.trg_stable <= 1'b0;
      s.ap_valid <= 1'b0;
      s.ap_write <= 1'b0;
      s.ap_hit <= 1'b0;
      s.ap_addr <= 8'h00;
      s.rd_wait <= 1'b0;
      s.ready <= 1'b1;
      s.rdata <= 32'h00000000;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Everything below is flip-flops or small gate logic on flip-flops
  assign hreadyout = s.ready;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign conv_pins.clk_en = gate_on; // RQ1 RQ2
  assign conv_pins.comparator_on = gate_on && s.mode0[BIT_CMP_EN]; // RQ6
  assign conv_pins.busy = (s.seq != SEQ_IDLE);
  assign conv_pins.channel = s.chan;
  assign port2_out_en = ~s.port2_dir[PORT_PINS-1:0]; // RQ13
  // Arbitration against other sources happens outside on this level
  assign conv_end_request = s.flag1h[BIT_CONV_END] && !s.mask1h[BIT_CONV_END]; // RQ15
  assign conv_end_priority = {s.prio_hi[BIT_CONV_END], s.prio_lo[BIT_CONV_END]}; // RQ12
  assign irq = |(s.irq_status & s.irq_enable);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  gate_write_block_a: assert property ( // RQ1
    wr && s.ap_addr == OFS_MODE0 && !gate_on |=> s.mode0 == $past(s.mode0))
    else $error("mode write took effect with clock gated");
  gate_clock_on_a: assert property ( // RQ2
    wr && s.ap_addr == OFS_CLOCK_GATE && hwdata[BIT_CLOCK_GATE] |=> conv_pins.clk_en)
    else $error("converter clock not supplied after gate set");
  stop_idles_a: assert property ( // RQ3
    wr && s.ap_addr == OFS_MODE0 && gate_on && !hwdata[BIT_RUN]
    |=> ##1 !conv_pins.busy)
    else $error("conversion did not stop");
  sw_busy_run_a: assert property ( // RQ4
    gate_on && s.seq == SEQ_CONV && !wait_mode
    |-> s.mode0[BIT_RUN] || $past(wr && s.ap_addr == OFS_MODE0))
    else $error("software mode busy with run bit clear");
  hw_stab_start_a: assert property ( // RQ5
    gate_on && run && wait_mode && s.seq == SEQ_IDLE && trg_rise
    |=> s.seq == SEQ_STAB ##1 rd_word(s, OFS_MODE0) == {24'h000000, s.mode0})
    else $error("trigger did not start stabilisation wait");
  cmp_off_idle_a: assert property ( // RQ6
    gate_on && !s.mode0[BIT_CMP_EN] |-> !conv_pins.comparator_on ##1 !conv_pins.busy)
    else $error("converter active with comparator off");
  mode_layout_a: assert property ( // RQ7
    wr && s.ap_addr == OFS_MODE0 && gate_on |=> s.mode0 == $past(hwdata[7:0]))
    else $error("mode register did not take written value");
  select_oneshot_a: assert property ( // RQ8
    conv_end && !scan && !wait_mode && !wr |=> !s.mode0[BIT_RUN] && !conv_pins.busy)
    else $error("single channel conversion did not end");
  scan_step_a: assert property ( // RQ9
    conv_end && scan && s.chan != LAST_SCAN_CHANNEL |=> s.chan == $past(s.chan) + 2'h1)
    else $error("scan did not advance channel");
  flag_set_a: assert property ( // RQ11
    conv_end |=> s.flag1h[BIT_CONV_END])
    else $error("conversion end did not set request flag");
  req_unmasked_a: assert property ( // RQ10
    conv_end && !s.mask1h[BIT_CONV_END] && !wr |=> conv_end_request)
    else $error("unmasked request not forwarded");
  prio_hi_a: assert property ( // RQ12
    wr && s.ap_addr == OFS_PRIO_HI |=> conv_end_priority[1] == $past(hwdata[0]))
    else $error("priority high bit not taken");
  port_dir_a: assert property ( // RQ13
    wr && s.ap_addr == OFS_PORT2_DIR
    |=> port2_out_en == ~$past(hwdata[PORT_PINS-1:0]))
    else $error("port direction not applied");
  masked_quiet_a: assert property ( // RQ15
    s.mask1h[BIT_CONV_END] |-> !conv_end_request)
    else $error("masked request forwarded");

  scan_done_c: cover property (scan_done);
  hw_wait_c: cover property (s.seq == SEQ_STAB ##1 s.seq == SEQ_CONV);
  status_read_c: cover property (s.rd_wait && s.ap_addr == OFS_IRQ_STATUS && irq);
  flag_clear_race_c: cover property (conv_end && wr && s.ap_addr == OFS_FLAG1H);

endmodule

`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the converter control block.
// Assumes the design answers on AHB-Lite as one slave, hready tied to hreadyout.
`timescale 1ns/1ps
`default_nettype none

module tb import adc_ctrl_pkg::*;;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hw_trigger = 1'b0;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  conv_pins_t conv_pins;
  logic [3:0] port2_out_en;
  logic conv_end_request;
  logic [1:0] conv_end_priority;
  logic irq;
  int n_errors = 0;
  int num_checks = 0;
  logic [3:0] seen;
  int busy_cycles = 0;
  int n0;
  // Short stabilisation wait keeps wait-mode runs brief
  localparam int unsigned STAB_N = 2;
  logic [7:0] ofs [10];
  logic [7:0] rst [10];

  assign hready = hreadyout;

  adc_control_and_end_interrupt #(.STAB_CYCLES(STAB_N), .PORT_PINS(4))
    adc_control_and_end_interrupt_inst (
    .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hw_trigger(hw_trigger),
    .conv_pins(conv_pins), .port2_out_en(port2_out_en),
    .conv_end_request(conv_end_request), .conv_end_priority(conv_end_priority), .irq(irq));

  always #50 core_clk = ~core_clk;

  // Busy length counter, compared against the conversion time
  always @(posedge core_clk) begin
    if (conv_pins.busy === 1'b1) begin
      busy_cycles <= busy_cycles + 1;
    end
  end

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus and wait helpers
  // ----------------------------------------------------------------
  // Bounded wait for hready sampled high; a hang ends the run
  task automatic edge_ready;
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (k >= 64) begin
      n_errors++;
      summarize();
    end
  endtask

  // One single word transfer; entered right after a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    edge_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    edge_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, {24'h000000, d}, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h00000000, q);
    chk(q, {24'h000000, exp});
  endtask

  // Waits for busy to reach a level, noting channels converted meanwhile
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
      if (conv_pins.busy === 1'b1 && !$isunknown(conv_pins.channel)) begin
        seen[conv_pins.channel] = 1'b1;
      end
    end while (conv_pins.busy !== lvl && k < 1000);
    if (k >= 1000) begin
      n_errors++;
      summarize();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ofs = '{OFS_CLOCK_GATE, OFS_MODE0, OFS_MASK1H, OFS_FLAG1H, OFS_PRIO_HI,
            OFS_PRIO_LO, OFS_PORT2_DIR, OFS_TRIG_CFG, OFS_IRQ_STATUS, OFS_IRQ_ENABLE};
    rst = '{RST_CLOCK_GATE, RST_MODE0, RST_MASK1H, RST_FLAG1H, RST_PRIO,
            RST_PRIO, RST_PORT2_DIR, RST_ZERO, RST_ZERO, RST_ZERO};
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 10; i++) begin
      rdchk(ofs[i], rst[i]);
    end
    chk({28'h0, port2_out_en}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({30'h0, conv_end_priority}, 32'h3);
    // Gate off: mode register must not take writes
    wr(OFS_MODE0, 8'h01);
    rdchk(OFS_MODE0, 8'h00);
    chk({31'h0, conv_pins.clk_en}, 32'h0);
    wr(OFS_CLOCK_GATE, 8'h20);
    wr(OFS_MODE0, 8'h01);
    @(posedge core_clk);
    chk({31'h0, conv_pins.clk_en}, 32'h1);
    chk({31'h0, conv_pins.comparator_on}, 32'h1);
    rdchk(OFS_MODE0, 8'h01);
    // Halt before configuring
    wr(OFS_MODE0, 8'h00);
    @(posedge core_clk);
    chk({31'h0, conv_pins.comparator_on}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_PORT2_DIR, 8'h05 << i[1:0]);
      wr(OFS_PRIO_HI, {7'h00, i[1]});
      wr(OFS_PRIO_LO, {7'h00, i[0]});
      @(posedge core_clk);
      chk({28'h0, port2_out_en}, {28'h0, ~(4'h5 << i[1:0])});
      chk({30'h0, conv_end_priority}, i[1:0]);
    end
    wr(OFS_IRQ_ENABLE, 8'h03);
    // Single channel conversion, fastest clock, longer timing
    seen = 4'h0;
    wr(OFS_MODE0, 8'hBD);
    n0 = busy_cycles;
    wait_busy(1'b1);
    rdchk(OFS_MODE0, 8'hBD);
    wait_busy(1'b0);
    chk({28'h0, seen}, 32'h1);
    chk(busy_cycles - n0, 2 * FAD_CLOCKS_NORMAL1);
    rdchk(OFS_MODE0, 8'h3D);
    rdchk(OFS_FLAG1H, 8'h01);
    chk({31'h0, conv_end_request}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    // Disabled status bit must keep the line quiet
    wr(OFS_IRQ_ENABLE, 8'h02);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_ENABLE, 8'h03);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_MASK1H, 8'h00);
    @(posedge core_clk);
    chk({31'h0, conv_end_request}, 32'h1);
    rdchk(OFS_IRQ_STATUS, 8'h01);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_FLAG1H, 8'h00);
    @(posedge core_clk);
    chk({31'h0, conv_end_request}, 32'h0);
    // Scan of four channels
    seen = 4'h0;
    wr(OFS_MODE0, 8'hFD);
    n0 = busy_cycles;
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk({28'h0, seen}, 32'hF);
    chk(busy_cycles - n0, 8 * FAD_CLOCKS_NORMAL1);
    rdchk(OFS_IRQ_STATUS, 8'h03);
    rdchk(OFS_MODE0, 8'h7D);
    wr(OFS_FLAG1H, 8'h00);
    // Stop in mid conversion leaves no request behind
    wr(OFS_MODE0, 8'hBD);
    wait_busy(1'b1);
    wr(OFS_MODE0, 8'h3D);
    repeat (2) @(posedge core_clk);
    chk({31'h0, conv_pins.busy}, 32'h0);
    rdchk(OFS_FLAG1H, 8'h00);
    // Hardware trigger wait mode
    wr(OFS_MODE0, 8'h00);
    wr(OFS_TRIG_CFG, 8'h01);
    wr(OFS_MODE0, 8'hBF);
    repeat (4) @(posedge core_clk);
    chk({31'h0, conv_pins.busy}, 32'h0);
    n0 = busy_cycles;
    hw_trigger <= 1'b1;
    wait_busy(1'b1);
    hw_trigger <= 1'b0;
    rdchk(OFS_MODE0, 8'hBF);
    wait_busy(1'b0);
    chk(busy_cycles - n0, STAB_N + 2 * FAD_CLOCKS_NORMAL2);
    rdchk(OFS_FLAG1H, 8'h01);
    wr(OFS_MODE0, 8'h00);
    wr(OFS_TRIG_CFG, 8'h00);
    // Gate off again, then an unmapped place
    wr(OFS_CLOCK_GATE, 8'h00);
    wr(OFS_MODE0, 8'h01);
    @(posedge core_clk);
    chk({31'h0, conv_pins.clk_en}, 32'h0);
    rdchk(OFS_MODE0, 8'h00);
    rdchk(8'h40, 8'h00);
    summarize();
  end
endmodule

`default_nettype wire
